// ---- rtl/ucm_top.v ----
`timescale 1ns/1ns
`default_nettype none
`include "ucm_consts.vh"
module ucm_top (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire rx_char_valid,
	input wire [8:0] rx_char_data,
	input wire rx_parity_err,
	input wire rx_frame_err,
	input wire rx_overrun,
	input wire rx_manch_err,
	input wire rx_break_seen,
	input wire iter_event,
	input wire nack_event,
	input wire tx_ready_in,
	input wire tx_drained_in,
	input wire bit_tick,
	input wire tx_serial,
	input wire rxd_pin,
	input wire ri_in,
	input wire dsr_in,
	input wire dcd_in,
	input wire cts_in,
	output reg txd_r,
	output reg rx_line_r,
	output reg rx_on_r,
	output reg tx_on_r,
	output reg rx_reset_r,
	output reg tx_reset_r,
	output reg dtr_n_r,
	output reg rts_n_r,
	output reg sck_oe_r,
	output reg [1:0] clk_src_r,
	output reg sync_r,
	output reg [3:0] char_bits_r,
	output reg [2:0] parity_type_r,
	output reg [1:0] stop_code_r,
	output reg stop_half_r,
	output reg msb_first_r,
	output reg [15:0] baud_div_r,
	output reg [8:0] thr_data_r,
	output reg thr_load_r,
	output reg thr_addr_bit_r
);
	reg [31:0] mode_r;
	reg [31:0] imr_r;
	reg [15:0] rtor_r;
	reg [7:0] ttgr_r;
	reg [10:0] fidi_r;
	reg [7:0] ner_r;
	reg [7:0] if_r;
	reg [31:0] man_r;
	reg [8:0] rhr_r;
	reg rxrdy_r;
	reg parity_error_flag_r;
	reg frame_r;
	reg overrun_flag_r;
	reg manchester_error_flag_r;
	reg break_received_flag_r;
	reg iter_r;
	reg nack_r;
	reg to_flag_r;
	reg to_wait_r;
	reg to_run_r;
	reg [15:0] to_cnt_r;
	reg addr_pend_r;
	reg rts_lvl_r;
	reg [31:0] rd_nxt;
	wire [3:0] chg_w;
	wire [3:0] lvl_w;
	wire [31:0] csr_w;
	wire brk_low;
	wire setup_ph;
	wire acc_ph;
	wire wr_en;
	wire rd_en;
	wire cr_wr;
	wire [3:0] proto;
	wire [1:0] loop_cfg;
	wire par_none;
	wire par_multi;
	wire [3:0] frame_bits;
	wire [3:0] modem_clr;

	// Smart-card protocols alone let a command clear the retry flag; the acknowledge clear is not gated.
	function iso_mode;
		input [3:0] m;
		begin
			iso_mode = (m == `UCM_PROTO_ISO_T0) || (m == `UCM_PROTO_ISO_T1);
		end
	endfunction

	// Mapped register offsets; anything else answers with an error.
	function mapped;
		input [7:0] a;
		begin
			mapped = (a <= `UCM_OFF_TTGR) || (a == `UCM_OFF_FIDI) || (a == `UCM_OFF_NER) ||
				(a == `UCM_OFF_IF) || (a == `UCM_OFF_MAN);
		end
	endfunction

	// Bus phases; a write or read side effect happens only at the completing edge.
	assign setup_ph = psel && !penable;
	assign acc_ph = psel && penable && pready;
	assign wr_en = acc_ph && pwrite && !pslverr;
	assign rd_en = acc_ph && !pwrite && !pslverr;
	assign cr_wr = wr_en && (paddr == `UCM_OFF_CR);

	// Mode fields.
	assign proto = mode_r[3:0];
	assign loop_cfg = mode_r[15:14];
	assign par_none = (mode_r[11:10] == 2'b10);
	assign par_multi = (mode_r[11:10] == 2'b11);
	assign frame_bits = char_bits_r + 4'h2 + {3'h0, !par_none} + {3'h0, stop_code_r[1]};

	// Change flags that were shown in the captured status word are cleared on its read.
	assign modem_clr = (rd_en && (paddr == `UCM_OFF_CSR)) ? prdata[19:16] : 4'h0;

	assign csr_w = {7'h00, manchester_error_flag_r, lvl_w[3], lvl_w[2], lvl_w[1], lvl_w[0],
		chg_w[3], chg_w[2], chg_w[1], chg_w[0], 2'h0, nack_r, 2'h0, iter_r,
		tx_drained_in, to_flag_r, parity_error_flag_r, frame_r, overrun_flag_r, 2'h0, break_received_flag_r,
		tx_ready_in, rxrdy_r};

	ucm_modem_watch u_modem (
		.pclk(pclk),
		.presetn(presetn),
		.watch_en(proto == `UCM_PROTO_MODEM),
		.lvl_in({cts_in, dcd_in, dsr_in, ri_in}),
		.clr_mask(modem_clr),
		.chg_r(chg_w),
		.lvl_r(lvl_w)
	);

	ucm_break_seq u_brk (
		.pclk(pclk),
		.presetn(presetn),
		.begin_cmd(cr_wr && pwdata[`UCM_CR_BRKBEG]),
		.end_cmd(cr_wr && pwdata[`UCM_CR_BRKEND]),
		.tx_drained(tx_drained_in),
		.bit_tick(bit_tick),
		.frame_bits(frame_bits),
		.line_low(brk_low),
		.busy()
	);

	// Read multiplexer; write-only and unmapped words read as zero.
	always @*
	begin
		rd_nxt = 32'h0;
		if (paddr == `UCM_OFF_MR)
			rd_nxt = mode_r;
		else if (paddr == `UCM_OFF_IMR)
			rd_nxt = imr_r;
		else if (paddr == `UCM_OFF_CSR)
			rd_nxt = csr_w;
		else if (paddr == `UCM_OFF_RHR)
			rd_nxt = {23'h0, rhr_r};
		else if (paddr == `UCM_OFF_BRGR)
			rd_nxt = {16'h0, baud_div_r};
		else if (paddr == `UCM_OFF_RTOR)
			rd_nxt = {16'h0, rtor_r};
		else if (paddr == `UCM_OFF_TTGR)
			rd_nxt = {24'h0, ttgr_r};
		else if (paddr == `UCM_OFF_FIDI)
			rd_nxt = {21'h0, fidi_r};
		else if (paddr == `UCM_OFF_NER)
			rd_nxt = {24'h0, ner_r};
		else if (paddr == `UCM_OFF_IF)
			rd_nxt = {24'h0, if_r};
		else if (paddr == `UCM_OFF_MAN)
			rd_nxt = man_r;
	end

	// Bus slave: read data and ready are captured in the setup cycle, one access cycle.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= setup_ph;
			pslverr <= setup_ph && !mapped(paddr);
			if (setup_ph)
				prdata <= rd_nxt;
		end
	end

	// Configuration registers written by software.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_r <= `UCM_RST_MR;
			imr_r <= 32'h0;
			baud_div_r <= 16'h0;
			rtor_r <= 16'h0;
			ttgr_r <= 8'h0;
			fidi_r <= `UCM_RST_FIDI;
			if_r <= 8'h0;
			man_r <= `UCM_RST_MAN;
		end
		else if (wr_en)
		begin
			if (paddr == `UCM_OFF_MR)
				mode_r <= pwdata;
			else if (paddr == `UCM_OFF_IER)
				imr_r <= imr_r | (pwdata & `UCM_IMR_MASK);
			else if (paddr == `UCM_OFF_IDR)
				imr_r <= imr_r & ~pwdata;
			else if (paddr == `UCM_OFF_BRGR)
				baud_div_r <= pwdata[15:0];
			else if (paddr == `UCM_OFF_RTOR)
				rtor_r <= pwdata[15:0];
			else if (paddr == `UCM_OFF_TTGR)
				ttgr_r <= pwdata[7:0];
			else if (paddr == `UCM_OFF_FIDI)
				fidi_r <= pwdata[10:0];
			else if (paddr == `UCM_OFF_IF)
				if_r <= pwdata[7:0];
			else if (paddr == `UCM_OFF_MAN)
				man_r <= pwdata;
		end
	end

	// Command register: set bits act in that write; with both of a pair set, off wins for rx/tx and on wins for DTR and RTS.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_on_r <= 1'b0;
			tx_on_r <= 1'b0;
			rx_reset_r <= 1'b0;
			tx_reset_r <= 1'b0;
			dtr_n_r <= 1'b1;
			rts_lvl_r <= 1'b1;
		end
		else
		begin
			rx_reset_r <= cr_wr && pwdata[`UCM_CR_RSTRX];
			tx_reset_r <= cr_wr && pwdata[`UCM_CR_RSTTX];
			if (cr_wr)
			begin
				if (pwdata[`UCM_CR_RXOFF])
					rx_on_r <= 1'b0;
				else if (pwdata[`UCM_CR_RXON])
					rx_on_r <= 1'b1;
				if (pwdata[`UCM_CR_TXOFF])
					tx_on_r <= 1'b0;
				else if (pwdata[`UCM_CR_TXON])
					tx_on_r <= 1'b1;
				if (pwdata[`UCM_CR_DTRON])
					dtr_n_r <= 1'b0;
				else if (pwdata[`UCM_CR_DTROFF])
					dtr_n_r <= 1'b1;
				if (pwdata[`UCM_CR_RTSON])
					rts_lvl_r <= 1'b0;
				else if (pwdata[`UCM_CR_RTSOFF])
					rts_lvl_r <= 1'b1;
			end
		end
	end

	// Sticky receive and protocol flags; a new event wins over a clear.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			parity_error_flag_r <= 1'b0;
			frame_r <= 1'b0;
			overrun_flag_r <= 1'b0;
			manchester_error_flag_r <= 1'b0;
			break_received_flag_r <= 1'b0;
			iter_r <= 1'b0;
			nack_r <= 1'b0;
			rxrdy_r <= 1'b0;
			rhr_r <= 9'h0;
			ner_r <= 8'h0;
		end
		else
		begin
			if (cr_wr && pwdata[`UCM_CR_CLRERR])
			begin
				parity_error_flag_r <= 1'b0;
				frame_r <= 1'b0;
				overrun_flag_r <= 1'b0;
				manchester_error_flag_r <= 1'b0;
				break_received_flag_r <= 1'b0;
			end
			if (rx_parity_err)
				parity_error_flag_r <= 1'b1;
			if (rx_frame_err)
				frame_r <= 1'b1;
			if (rx_overrun)
				overrun_flag_r <= 1'b1;
			if (rx_manch_err)
				manchester_error_flag_r <= 1'b1;
			if (rx_break_seen)
				break_received_flag_r <= 1'b1;
			if (iter_event)
				iter_r <= 1'b1;
			else if (cr_wr && pwdata[`UCM_CR_CLRIT] && iso_mode(proto))
				iter_r <= 1'b0;
			if (nack_event)
				nack_r <= 1'b1;
			else if (cr_wr && pwdata[`UCM_CR_CLRNACK])
				nack_r <= 1'b0;
			if (rx_char_valid)
			begin
				rhr_r <= rx_char_data;
				rxrdy_r <= 1'b1;
			end
			else if (rd_en && (paddr == `UCM_OFF_RHR))
				rxrdy_r <= 1'b0;
			if (rd_en && (paddr == `UCM_OFF_NER))
				ner_r <= {7'h0, rx_parity_err};
			else if (rx_parity_err && (ner_r != 8'hff))
				ner_r <= ner_r + 8'h01;
		end
	end

	// Receive idle timer: armed, it waits for a character before counting bit periods.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			to_flag_r <= 1'b0;
			to_wait_r <= 1'b0;
			to_run_r <= 1'b0;
			to_cnt_r <= 16'h0;
		end
		else
		begin
			if (cr_wr && pwdata[`UCM_CR_ARMTO])
			begin
				to_flag_r <= 1'b0;
				to_wait_r <= 1'b1;
				to_run_r <= 1'b0;
			end
			else if (cr_wr && pwdata[`UCM_CR_RETTO])
			begin
				to_wait_r <= 1'b0;
				to_run_r <= (rtor_r != 16'h0);
				to_cnt_r <= rtor_r;
			end
			else if (rx_char_valid && (to_wait_r || to_run_r))
			begin
				to_wait_r <= 1'b0;
				to_run_r <= (rtor_r != 16'h0);
				to_cnt_r <= rtor_r;
			end
			else if (to_run_r && bit_tick)
			begin
				to_cnt_r <= to_cnt_r - 16'h1;
				if (to_cnt_r == 16'h1)
					to_run_r <= 1'b0;
			end
			// An expiry in the same cycle as an arm or a reload still raises the flag.
			if (to_run_r && bit_tick && (to_cnt_r == 16'h1))
				to_flag_r <= 1'b1;
		end
	end

	// Holding register hand-off; the address bit is taken by the next character.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			thr_data_r <= 9'h0;
			thr_load_r <= 1'b0;
			thr_addr_bit_r <= 1'b0;
			addr_pend_r <= 1'b0;
		end
		else
		begin
			thr_load_r <= wr_en && (paddr == `UCM_OFF_THR);
			if (wr_en && (paddr == `UCM_OFF_THR))
			begin
				thr_data_r <= pwdata[8:0];
				thr_addr_bit_r <= addr_pend_r && par_multi;
				addr_pend_r <= 1'b0;
			end
			else if (cr_wr && pwdata[`UCM_CR_ADDR] && par_multi)
				addr_pend_r <= 1'b1;
		end
	end

	// Decoded format outputs for the shifters and the baud generator.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			clk_src_r <= 2'h0;
			sck_oe_r <= 1'b0;
			sync_r <= 1'b0;
			char_bits_r <= 4'h5;
			parity_type_r <= 3'h0;
			stop_code_r <= 2'h0;
			stop_half_r <= 1'b0;
			msb_first_r <= 1'b0;
			rts_n_r <= 1'b1;
		end
		else
		begin
			clk_src_r <= mode_r[5:4];
			sck_oe_r <= mode_r[18] && (mode_r[5:4] != `UCM_CLK_EXT);
			sync_r <= mode_r[8];
			char_bits_r <= mode_r[17] ? 4'h9 : (4'h5 + {2'h0, mode_r[7:6]});
			parity_type_r <= mode_r[11:9];
			stop_code_r <= mode_r[13:12];
			stop_half_r <= (mode_r[13:12] == 2'b01) && !mode_r[8];
			msb_first_r <= mode_r[16];
			if (proto == `UCM_PROTO_RS485)
				rts_n_r <= !tx_drained_in;
			else
				rts_n_r <= rts_lvl_r;
		end
	end

	// Channel routing of the serial lines, with the break forcing the transmit path low.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			txd_r <= 1'b1;
			rx_line_r <= 1'b1;
		end
		else
		begin
			case (loop_cfg)
				`UCM_LOOP_ECHO:
				begin
					txd_r <= rxd_pin;
					rx_line_r <= rxd_pin;
				end
				`UCM_LOOP_LOCAL:
				begin
					txd_r <= 1'b1;
					rx_line_r <= tx_serial && !brk_low;
				end
				`UCM_LOOP_REMOTE:
				begin
					txd_r <= rxd_pin;
					rx_line_r <= 1'b1;
				end
				default:
				begin
					txd_r <= tx_serial && !brk_low;
					rx_line_r <= rxd_pin;
				end
			endcase
		end
	end
endmodule // ucm_top
`default_nettype wire

// ---- rtl/ucm_consts.vh ----
`ifndef UCM_CONSTS_VH
`define UCM_CONSTS_VH
`define UCM_OFF_CR 8'h00
`define UCM_OFF_MR 8'h04
`define UCM_OFF_IER 8'h08
`define UCM_OFF_IDR 8'h0c
`define UCM_OFF_IMR 8'h10
`define UCM_OFF_CSR 8'h14
`define UCM_OFF_RHR 8'h18
`define UCM_OFF_THR 8'h1c
`define UCM_OFF_BRGR 8'h20
`define UCM_OFF_RTOR 8'h24
`define UCM_OFF_TTGR 8'h28
`define UCM_OFF_FIDI 8'h40
`define UCM_OFF_NER 8'h44
`define UCM_OFF_IF 8'h4c
`define UCM_OFF_MAN 8'h50
`define UCM_RST_FIDI 11'h174
`define UCM_RST_MAN 32'h30011004
`define UCM_RST_MR 32'h00000000
`define UCM_IMR_MASK 32'h011f3fff
`define UCM_CR_RSTRX 2
`define UCM_CR_RSTTX 3
`define UCM_CR_RXON 4
`define UCM_CR_RXOFF 5
`define UCM_CR_TXON 6
`define UCM_CR_TXOFF 7
`define UCM_CR_CLRERR 8
`define UCM_CR_BRKBEG 9
`define UCM_CR_BRKEND 10
`define UCM_CR_ARMTO 11
`define UCM_CR_ADDR 12
`define UCM_CR_CLRIT 13
`define UCM_CR_CLRNACK 14
`define UCM_CR_RETTO 15
`define UCM_CR_DTRON 16
`define UCM_CR_DTROFF 17
`define UCM_CR_RTSON 18
`define UCM_CR_RTSOFF 19
`define UCM_PROTO_NORMAL 4'h0
`define UCM_PROTO_RS485 4'h1
`define UCM_PROTO_HANDSHAKE 4'h2
`define UCM_PROTO_MODEM 4'h3
`define UCM_PROTO_ISO_T0 4'h4
`define UCM_PROTO_ISO_T1 4'h6
`define UCM_PROTO_IRDA 4'h8
`define UCM_CLK_EXT 2'h3
`define UCM_LOOP_NORMAL 2'h0
`define UCM_LOOP_ECHO 2'h1
`define UCM_LOOP_LOCAL 2'h2
`define UCM_LOOP_REMOTE 2'h3
`define UCM_BRK_MARK_BITS 4'hc
`endif

// ---- rtl/ucm_modem_watch.v ----
`timescale 1ns/1ns
`default_nettype none
module ucm_modem_watch (
	input wire pclk,
	input wire presetn,
	input wire watch_en,
	input wire [3:0] lvl_in,
	input wire [3:0] clr_mask,
	output reg [3:0] chg_r,
	output reg [3:0] lvl_r
);
	genvar i;
	// One change detector per modem input; a new change beats a read clear.
	generate
		for (i = 0; i < 4; i = i + 1)
		begin : g_line
			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					lvl_r[i] <= 1'b1;
					chg_r[i] <= 1'b0;
				end
				else
				begin
					lvl_r[i] <= lvl_in[i];
					if (watch_en && (lvl_in[i] != lvl_r[i]))
						chg_r[i] <= 1'b1;
					else if (clr_mask[i])
						chg_r[i] <= 1'b0;
				end
			end
		end
	endgenerate
endmodule // ucm_modem_watch
`default_nettype wire

// ---- rtl/ucm_break_seq.v ----
`timescale 1ns/1ns
`default_nettype none
`include "ucm_consts.vh"
module ucm_break_seq (
	input wire pclk,
	input wire presetn,
	input wire begin_cmd,
	input wire end_cmd,
	input wire tx_drained,
	input wire bit_tick,
	input wire [3:0] frame_bits,
	output wire line_low,
	output wire busy
);
	localparam S_IDLE = 4'b0001;
	localparam S_DRAIN = 4'b0010;
	localparam S_BRK = 4'b0100;
	localparam S_MARK = 4'b1000;
	reg [3:0] state_r;
	reg [3:0] cnt_r;
	reg stop_req_r;
	assign line_low = state_r[2];
	assign busy = !state_r[0];
	// Break sequencer: wait for drain, hold low, then idle marks.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= S_IDLE;
			cnt_r <= 4'h0;
			stop_req_r <= 1'b0;
		end
		else
		begin
			case (state_r)
				S_IDLE:
				begin
					if (begin_cmd)
						state_r <= S_DRAIN;
				end
				S_DRAIN:
				begin
					if (tx_drained)
					begin
						state_r <= S_BRK;
						cnt_r <= 4'h0;
						stop_req_r <= 1'b0;
					end
				end
				S_BRK:
				begin
					if (end_cmd)
						stop_req_r <= 1'b1;
					// The first tick may come right away, so one extra tick makes a full character.
					if ((stop_req_r || end_cmd) && (cnt_r > frame_bits))
					begin
						state_r <= S_MARK;
						cnt_r <= 4'h0;
					end
					else if (bit_tick && (cnt_r <= frame_bits))
						cnt_r <= cnt_r + 4'h1;
				end
				S_MARK:
				begin
					if (bit_tick)
					begin
						// One tick beyond the count keeps the mark for whole bit periods.
						if (cnt_r == `UCM_BRK_MARK_BITS)
							state_r <= S_IDLE;
						cnt_r <= cnt_r + 4'h1;
					end
				end
				default:
					state_r <= S_IDLE;
			endcase
		end
	end
endmodule // ucm_break_seq
`default_nettype wire

// ---- tb/ucm_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
module ucm_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic rx_on_r,
	input wire logic tx_on_r,
	input wire logic dtr_n_r,
	input wire logic sck_oe_r,
	input wire logic [3:0] char_bits_r,
	input wire logic msb_first_r
);
	// Completed writes to the command and mode words.
	wire cr_wr = psel && penable && pready && pwrite && paddr == 8'h00;
	wire mr_wr = psel && penable && pready && pwrite && paddr == 8'h04;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_pready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_unmapped_err: assert property (psel && !penable && paddr == 8'h2c |=> pslverr && pready)
		else $error("unmapped access not refused");
	a_rx_on_cmd: assert property (cr_wr && pwdata[4] && !pwdata[5] |-> ##2 rx_on_r)
		else $error("receiver not enabled");
	a_rx_off_cmd: assert property (cr_wr && pwdata[5] |-> ##2 !rx_on_r)
		else $error("receiver not disabled");
	a_tx_on_cmd: assert property (cr_wr && pwdata[6] && !pwdata[7] |-> ##2 tx_on_r)
		else $error("transmitter not enabled");
	a_tx_off_cmd: assert property (cr_wr && pwdata[7] |-> ##2 !tx_on_r)
		else $error("transmitter not disabled");
	a_dtr_low_cmd: assert property (cr_wr && pwdata[16] |-> ##2 !dtr_n_r)
		else $error("terminal ready not low");
	a_nine_bits: assert property (mr_wr && pwdata[17] |-> ##2 char_bits_r == 4'h9)
		else $error("nine bit length wrong");
	a_five_bits: assert property (mr_wr && pwdata[17:6] == 12'h000 |-> ##2 char_bits_r == 4'h5)
		else $error("five bit length wrong");
	a_msb_order: assert property (mr_wr && pwdata[16] |-> ##2 msb_first_r)
		else $error("bit order not msb first");
	a_sck_ext_off: assert property (mr_wr && pwdata[5:4] == 2'b11 |-> ##2 !sck_oe_r)
		else $error("clock pin driven with external clock");
endmodule // ucm_chk
bind ucm_top ucm_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pready, .pslverr, .rx_on_r, .tx_on_r, .dtr_n_r, .sck_oe_r, .char_bits_r, .msb_first_r);
`default_nettype wire

// ---- tb/ucm_far_end.sv ----
`timescale 1ns/1ns
`default_nettype none
module ucm_far_end (
	input wire logic pclk,
	input wire logic txd,
	input wire logic ring_go,
	input wire logic send_en,
	input wire logic send_bit,
	output logic rxd,
	output logic ri,
	output logic dsr,
	output logic dcd,
	output logic cts
);
	// Lines start at mark; dsr and dcd start high, ri and cts low.
	initial
	begin
		rxd = 1'b1;
		ri = 1'b0;
		dsr = 1'b1;
		dcd = 1'b1;
		cts = 1'b0;
	end
	// The far terminal echoes the line or sends its own bit, and rings on request.
	always @(posedge pclk)
	begin
		rxd <= send_en ? send_bit : txd;
		if (ring_go)
			ri <= !ri;
	end
endmodule // ucm_far_end
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, rd;
	logic [6:0] ev = 0;
	logic rx_char_valid = 0, tx_drained_in = 0, bit_tick = 0, ring_go = 0;
	logic [8:0] rx_char_data = 0;
	logic tx_ser = 1, rx_send = 0, rx_bit = 1;
	wire [31:0] prdata;
	wire pready, pslverr, txd_r, rx_line_r, rx_on_r, tx_on_r, rx_reset_r, tx_reset_r;
	wire dtr_n_r, rts_n_r, sck_oe_r, sync_r, stop_half_r, msb_first_r, thr_load_r;
	wire thr_addr_bit_r, rxd, ri, dsr, dcd, cts;
	wire [1:0] clk_src_r, stop_code_r;
	wire [3:0] char_bits_r;
	wire [2:0] parity_type_r;
	wire [15:0] baud_div_r;
	wire [8:0] thr_data_r;
	integer n_mismatch = 0, total_checks = 0, seed = 41, cyc = 0, lowt = 0, i, md, rxo = 0;
	integer txo = 0, ch;
	int pm [8] = '{0, 1, 2, 3, 4, 6, 8, 0};
	ucm_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .rx_char_valid, .rx_char_data, .rx_parity_err(ev[0]), .rx_frame_err(ev[1]),
		.rx_overrun(ev[2]), .rx_manch_err(ev[3]), .rx_break_seen(ev[4]), .iter_event(ev[5]),
		.nack_event(ev[6]), .tx_ready_in(1'b1), .tx_drained_in, .bit_tick, .tx_serial(tx_ser),
		.rxd_pin(rxd), .ri_in(ri), .dsr_in(dsr), .dcd_in(dcd), .cts_in(cts), .txd_r, .rx_line_r,
		.rx_on_r, .tx_on_r, .rx_reset_r, .tx_reset_r, .dtr_n_r, .rts_n_r, .sck_oe_r, .clk_src_r,
		.sync_r, .char_bits_r, .parity_type_r, .stop_code_r, .stop_half_r, .msb_first_r,
		.baud_div_r, .thr_data_r, .thr_load_r, .thr_addr_bit_r);
	ucm_far_end far (.pclk, .txd(txd_r), .ring_go, .send_en(rx_send), .send_bit(rx_bit), .rxd,
		.ri, .dsr, .dcd, .cts);
	// Free running clock.
	initial
	begin
		forever #50 pclk = ~pclk;
	end
	// Bit period ticks, hang limit and count of low line ticks.
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		bit_tick <= cyc % 4 == 3;
		if (!txd_r && bit_tick)
			lowt <= lowt + 1;
		if (cyc == 20000)
		begin
			n_mismatch++;
			final_report;
		end
	end
	// Compares one value and counts the result.
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One APB transfer; read data and error are taken at the ready edge.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// Lets command effects reach the outputs.
	task settle;
		repeat (3) @(posedge pclk);
		@(negedge pclk);
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Main sequence.
	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1;
		@(negedge pclk);
		chk("dtr_n", 1, dtr_n_r);
		chk("char_bits", 5, char_bits_r);
		apb(0, 8'h10, 0);
		chk("irq_mask", 0, rd);
		apb(0, 8'h40, 0);
		chk("clock_ratio", 32'h174, rd);
		apb(0, 8'h50, 0);
		chk("manchester", 32'h30011004, rd);
		apb(1, 8'h2c, 1);
		chk("unmapped err", 1, err);
		apb(1, 8'h20, 32'h0000a5c3);
		apb(0, 8'h20, 0);
		chk("baud_divider", 32'h0000a5c3, rd);
		chk("baud out", 32'h0000a5c3, baud_div_r);
		$display("test registers done");
		for (i = 0; i < 8; i++)
		begin
			md = ($random(seed) & 32'h00070100) | pm[i] | (i % 4) * 32'h1050 | i << 9;
			apb(1, 8'h04, md);
			apb(0, 8'h04, 0);
			chk("mode", md, rd);
			settle;
			chk("char_bits", md[17] ? 9 : 5 + md[7:6], char_bits_r);
			chk("sync", md[8], sync_r);
			chk("parity", md[11:9], parity_type_r);
			chk("stop", md[13:12], stop_code_r);
			chk("half stop", md[13:12] == 1 && !md[8], stop_half_r);
			chk("msb", md[16], msb_first_r);
			chk("clk src", md[5:4], clk_src_r);
			chk("sck oe", md[18] && md[5:4] != 3, sck_oe_r);
		end
		$display("test mode done");
		for (i = 0; i < 16; i++)
		begin
			apb(1, 8'h00, i << 4);
			rxo = i[1] ? 0 : i[0] ? 1 : rxo;
			txo = i[3] ? 0 : i[2] ? 1 : txo;
			settle;
			chk("rx on", rxo, rx_on_r);
			chk("tx on", txo, tx_on_r);
		end
		apb(1, 8'h00, 32'hc);
		@(negedge pclk);
		chk("rx reset", 1, rx_reset_r);
		chk("tx reset", 1, tx_reset_r);
		@(negedge pclk);
		chk("reset pulse", 0, rx_reset_r | tx_reset_r);
		apb(1, 8'h04, 0);
		for (i = 0; i < 4; i++)
		begin
			apb(1, 8'h00, 1 << (16 + i));
			settle;
			if (i < 2)
				chk("dtr_n", i, dtr_n_r);
			else
				chk("rts_n", i - 2, rts_n_r);
		end
		apb(1, 8'h04, 1);
		for (i = 0; i < 2; i++)
		begin
			@(posedge pclk) tx_drained_in <= i;
			settle;
			chk("rts_n rs485", !i, rts_n_r);
		end
		$display("test commands done");
		apb(1, 8'h04, 0);
		@(posedge pclk) ev <= 7'h7f;
		@(posedge pclk) ev <= 0;
		apb(0, 8'h14, 0);
		chk("flags", 32'h010024e4, rd & 32'h010024e4);
		apb(1, 8'h00, 32'h100);
		apb(0, 8'h14, 0);
		chk("flags cleared", 32'h2400, rd & 32'h010024e4);
		apb(1, 8'h00, 32'h2000);
		apb(0, 8'h14, 0);
		chk("retry kept", 32'h400, rd & 32'h400);
		apb(1, 8'h04, 4);
		apb(1, 8'h00, 32'h2000);
		apb(0, 8'h14, 0);
		chk("retry cleared", 0, rd & 32'h400);
		$display("test status done");
		apb(1, 8'h24, 3);
		apb(1, 8'h00, 32'h800);
		repeat (40) @(posedge pclk);
		apb(0, 8'h14, 0);
		chk("timer held", 0, rd[8]);
		ch = $random(seed) & 32'h1ff;
		@(posedge pclk) rx_char_valid <= 1;
		rx_char_data <= ch;
		@(posedge pclk) rx_char_valid <= 0;
		repeat (40) @(posedge pclk);
		apb(0, 8'h14, 0);
		chk("timer expired", 1, rd[8]);
		apb(0, 8'h18, 0);
		chk("rx_holding", ch, rd);
		apb(1, 8'h00, 32'h800);
		apb(0, 8'h14, 0);
		chk("timer rearmed", 0, rd[8]);
		$display("test timer done");
		apb(1, 8'h04, 32'h0c00);
		apb(1, 8'h00, 32'h1000);
		for (i = 0; i < 2; i++)
		begin
			apb(1, 8'h1c, 32'h5a + i);
			do @(negedge pclk); while (thr_load_r !== 1'b1);
			chk("thr data", 32'h5a + i, thr_data_r);
			chk("addr bit", i == 0, thr_addr_bit_r);
		end
		apb(1, 8'h04, 32'h08c0);
		tx_drained_in <= 0;
		apb(1, 8'h00, 32'h200);
		settle;
		chk("break waits", 1, txd_r);
		@(posedge pclk) tx_drained_in <= 1;
		settle;
		chk("break low", 0, txd_r);
		apb(1, 8'h00, 32'h400);
		while (txd_r !== 1'b1)
			@(posedge pclk);
		chk("low ticks", 1, lowt >= 10);
		apb(1, 8'h00, 32'h200);
		repeat (44) @(negedge pclk);
		chk("mark phase", 1, txd_r);
		$display("test break done");
		// Channel routing: the terminal sends its own bit while the transmitter shows another.
		for (i = 0; i < 8; i++)
		begin
			ch = $random(seed);
			@(posedge pclk);
			tx_ser <= ch[0];
			rx_send <= 1;
			rx_bit <= ch[1];
			apb(1, 8'h04, (i % 4) << 14);
			settle;
			chk("txd", i % 4 == 2 ? 1 : i % 4 == 0 ? ch[0] : ch[1], txd_r);
			chk("rx line", i % 4 == 2 ? ch[0] : i % 4 == 3 ? 1 : ch[1], rx_line_r);
		end
		@(posedge pclk);
		rx_send <= 0;
		tx_ser <= 1;
		$display("test loop done");
		apb(1, 8'h04, 3);
		@(posedge pclk) ring_go <= 1;
		@(posedge pclk) ring_go <= 0;
		settle;
		apb(0, 8'h14, 0);
		chk("ring change", 1, rd[16]);
		apb(0, 8'h14, 0);
		chk("ring cleared", 0, rd[16]);
		$display("test modem done");
		final_report;
	end
endmodule // tb_top
`default_nettype wire
